// ### hw/sdc_sequencer.v
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "sdc_consts.vh"
// Notes on behaviour
// - sector codes act on header, optional data field one and optional data field two
// - each operation has a no-step code and a step code differing in bit four
// - verify header compares disk header with expected bytes; mismatch flags not-verified
// - verify-then-write writes data fields only after header matches, else ends
// - write-header codes write header then selected data fields
// - at-target write codes wait for target sector, then write header and fields
// - skip header moves no data, ends status sequence at header end
// - skip-then-read codes skip header and read selected data fields
// - read-header codes read header then selected data fields
// - at-target read codes wait for target sector, then read header and fields
// - step head code advances head address, moves no data
// - any exception bit raises status pending and attention when enabled
// - read status sends response; success octet clears all bits except a drive fault still present, else kept
// - logical interface reset clears every exception bit
// - accepting a bus control other than read status clears all but unsolicited bits
// - drive fault cleared by status read only if fault condition gone
// - status octet zero bit seven always sent as zero
// - unsolicited flag set with octet one cause; cleared only by successful read status or logical interface reset
// - unsolicited pending rejects every bus control except read status
// - rejected bus control sets bus control exception and an octet two cause
// - code bits: seven data, six read, four step, three header, one/zero fields
// - step bit advances head counter at end of a successful transfer
// - target sector is the one last loaded by the controller
module sdc_sequencer #(
  parameter HEAD_W = 8,
  parameter SECT_W = 16
) (
  // clock and reset
  input wire SYS_CLK,
  input wire NRST,
  // ahb-lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // disk timing
  input wire SECTOR_MARK,
  input wire FIELD_END,
  input wire [SECT_W-1:0] CUR_SECTOR,
  input wire [31:0] DISK_HDR,
  // exception sources
  input wire [7:0] UNSOL_EVT,
  input wire DRIVE_FAULT,
  // drive side controls
  output reg WR_GATE,
  output reg RD_GATE,
  output reg [1:0] FIELD_SEL,
  output reg [HEAD_W-1:0] HEAD_ADDR,
  output reg XFER_END,
  output reg STAT_PEND_IRQ,
  output reg ATTN_IN
);

  localparam S_IDLE = 6'b000001;
  localparam S_SYNC = 6'b000010;
  localparam S_TGT = 6'b000100;
  localparam S_HDR = 6'b001000;
  localparam S_DF1 = 6'b010000;
  localparam S_DF2 = 6'b100000;

  function is_sector_code;
    input [7:0] c;
    begin
      is_sector_code = c[`SDC_DC_DATA] && !c[`SDC_DC_FIXED] &&
                       (c[`SDC_DC_HDR] || c[`SDC_DC_MOD]);
    end
  endfunction

  // bus phase capture
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  wire ahb_go = HSEL && HREADY && (HTRANS == `SDC_HTRANS_NONSEQ);
  wire rd_go = ahb_go && !HWRITE;
  // software registers
  reg irq_en_r;
  reg attn_en_r;
  reg [SECT_W-1:0] target_r;
  reg [31:0] hdr_exp_r;
  reg [7:0] last_code_r;
  // exception state
  reg unsol_r;
  reg [7:0] oct1_r;
  reg bce_r;
  reg [7:3] oct2_r;
  reg fault_r;
  reg rs_wait_r;
  reg [2:0] stat_ptr_r;
  // sequencer
  reg [5:0] state_r;
  reg [7:0] op_r;
  reg hdr_nv_r;
  reg ok_r;

  wire wr_ctrl = wr_pend_r && (wr_addr_r == `SDC_A_CTRL);
  wire wr_bc = wr_pend_r && (wr_addr_r == `SDC_A_BUSCTL);
  wire wr_cs = wr_pend_r && (wr_addr_r == `SDC_A_CSTAT);
  wire lirst = wr_ctrl && HWDATA[`SDC_CTRL_LIRST];
  wire [7:0] code = HWDATA[7:0];
  wire is_rs = (code == `SDC_RD_STATUS);
  wire is_step = (code == `SDC_CODE_STEP);
  wire is_sect = is_sector_code(code);
  wire bad_code = (code[`SDC_DC_DATA] && code[`SDC_DC_FIXED]) || (code == `SDC_CODE_RSVD);
  // field controls and other commands are not handled by this block
  wire unsup = !bad_code && !is_rs && !is_step && !is_sect;
  wire busy = (state_r != S_IDLE);
  wire rej_unsol = unsol_r && !is_rs;
  wire rej_ctx = rej_unsol || (busy && !is_rs);
  wire reject = wr_bc && (bad_code || unsup || rej_ctx);
  wire accept = wr_bc && !reject;
  wire cs_ok = wr_cs && rs_wait_r && HWDATA[`SDC_CS_OK];
  wire hdr_match = (DISK_HDR == hdr_exp_r);
  wire verify_op = !op_r[`SDC_DC_READ] && op_r[`SDC_DC_MOD] && !op_r[`SDC_DC_HDR];
  wire done_ev = busy && FIELD_END &&
                 ((state_r == S_DF2) || (state_r == S_DF1 && !op_r[`SDC_DC_DF2]) ||
                  (state_r == S_HDR && ((verify_op && !hdr_match) ||
                   !(op_r[`SDC_DC_DF1] || op_r[`SDC_DC_DF2]))));
  wire done_ok = done_ev && !(state_r == S_HDR && verify_op && !hdr_match);
  wire [7:0] oct0 = {1'b0, unsol_r, bce_r, 4'h0, fault_r};
  wire pending = |oct0 || |oct1_r || |oct2_r;

  // bus slave
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_r <= ahb_go && HWRITE && (HSIZE == `SDC_HSIZE_WORD);
      wr_addr_r <= HADDR[7:0];
      if (rd_go) begin
        if (HADDR[7:0] == `SDC_A_CTRL)
          HRDATA <= {30'h0, attn_en_r, irq_en_r};
        else if (HADDR[7:0] == `SDC_A_BUSCTL)
          HRDATA <= {24'h0, last_code_r};
        else if (HADDR[7:0] == `SDC_A_TARGET)
          HRDATA <= {{(32-SECT_W){1'b0}}, target_r};
        else if (HADDR[7:0] == `SDC_A_HDREXP)
          HRDATA <= hdr_exp_r;
        else if (HADDR[7:0] == `SDC_A_STATDATA) begin
          // ascending octets, zeros once past the last one
          if (stat_ptr_r == 3'h0)
            HRDATA <= {24'h0, oct0};
          else if (stat_ptr_r == 3'h1)
            HRDATA <= {24'h0, oct1_r};
          else if (stat_ptr_r == 3'h2)
            HRDATA <= {24'h0, oct2_r, 3'h0};
          else
            HRDATA <= 32'h0000_0000;
        end else if (HADDR[7:0] == `SDC_A_SEQ)
          HRDATA <= {{(16-HEAD_W){1'b0}}, HEAD_ADDR, 5'h0, ok_r, hdr_nv_r, rs_wait_r,
                     2'h0, state_r};
        else if (HADDR[7:0] == `SDC_A_EXC)
          HRDATA <= {8'h00, oct2_r, 3'h0, oct1_r, oct0};
        else
          HRDATA <= 32'h0000_0000;
      end
    end
  end

  // software registers
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      irq_en_r <= 1'b0;
      attn_en_r <= 1'b0;
      target_r <= {SECT_W{1'b0}};
      hdr_exp_r <= 32'h0000_0000;
      last_code_r <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        irq_en_r <= HWDATA[`SDC_CTRL_IRQEN];
        attn_en_r <= HWDATA[`SDC_CTRL_ATTNEN];
      end
      if (wr_pend_r && wr_addr_r == `SDC_A_TARGET)
        target_r <= HWDATA[SECT_W-1:0];
      if (wr_pend_r && wr_addr_r == `SDC_A_HDREXP)
        hdr_exp_r <= HWDATA;
      if (wr_bc)
        last_code_r <= code;
    end
  end

  // exception status; every clear is written first so a same-cycle set wins
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      unsol_r <= 1'b0;
      oct1_r <= 8'h00;
      bce_r <= 1'b0;
      oct2_r <= 5'h00;
      fault_r <= 1'b0;
      rs_wait_r <= 1'b0;
      stat_ptr_r <= 3'h0;
    end else begin
      // read status itself keeps the bits it is about to report
      if (accept && !is_rs) begin
        bce_r <= 1'b0;
        oct2_r <= 5'h00;
        fault_r <= 1'b0;
      end
      if (cs_ok) begin
        unsol_r <= 1'b0;
        oct1_r <= 8'h00;
        bce_r <= 1'b0;
        oct2_r <= 5'h00;
        if (!DRIVE_FAULT)
          fault_r <= 1'b0;
      end
      if (lirst) begin
        unsol_r <= 1'b0;
        oct1_r <= 8'h00;
        bce_r <= 1'b0;
        oct2_r <= 5'h00;
        fault_r <= 1'b0;
      end
      if (wr_cs)
        rs_wait_r <= 1'b0;
      if (accept && is_rs) begin
        rs_wait_r <= 1'b1;
        stat_ptr_r <= 3'h0;
      end else if (rd_go && HADDR[7:0] == `SDC_A_STATDATA && stat_ptr_r != `SDC_STAT_OCTETS)
        stat_ptr_r <= stat_ptr_r + 3'h1;
      // sets
      if (|UNSOL_EVT) begin
        unsol_r <= 1'b1;
        oct1_r <= ((cs_ok || lirst) ? 8'h00 : oct1_r) | UNSOL_EVT;
      end
      if (DRIVE_FAULT)
        fault_r <= 1'b1;
      if (reject) begin
        bce_r <= 1'b1;
        if (bad_code)
          oct2_r[`SDC_O2_INVALID] <= 1'b1;
        else if (rej_ctx)
          oct2_r[`SDC_O2_CONTEXT] <= 1'b1;
        else
          oct2_r[`SDC_O2_UNSUP] <= 1'b1;
      end
    end
  end

  // sector sequencer
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      state_r <= S_IDLE;
      op_r <= 8'h00;
      hdr_nv_r <= 1'b0;
      ok_r <= 1'b0;
      HEAD_ADDR <= {HEAD_W{1'b0}};
      XFER_END <= 1'b0;
    end else begin
      XFER_END <= done_ev;
      if (accept && is_step)
        HEAD_ADDR <= HEAD_ADDR + 1'b1;
      if (done_ok && op_r[`SDC_DC_STEP])
        HEAD_ADDR <= HEAD_ADDR + 1'b1;
      if (lirst) begin
        state_r <= S_IDLE;
      end else begin
        case (state_r)
          S_IDLE: begin
            if (accept && is_sect) begin
              op_r <= code;
              hdr_nv_r <= 1'b0;
              ok_r <= 1'b0;
              // target bit only counts together with the header bit
              if (code[`SDC_DC_HDR] && code[`SDC_DC_MOD])
                state_r <= S_TGT;
              else
                state_r <= S_SYNC;
            end
          end
          S_SYNC: begin
            if (SECTOR_MARK)
              state_r <= S_HDR;
          end
          S_TGT: begin
            if (SECTOR_MARK && CUR_SECTOR == target_r)
              state_r <= S_HDR;
          end
          S_HDR: begin
            if (FIELD_END) begin
              if (verify_op && !hdr_match) begin
                hdr_nv_r <= 1'b1;
                state_r <= S_IDLE;
              end else if (op_r[`SDC_DC_DF1])
                state_r <= S_DF1;
              else if (op_r[`SDC_DC_DF2])
                state_r <= S_DF2;
              else begin
                ok_r <= 1'b1;
                state_r <= S_IDLE;
              end
            end
          end
          S_DF1: begin
            if (FIELD_END) begin
              if (op_r[`SDC_DC_DF2])
                state_r <= S_DF2;
              else begin
                ok_r <= 1'b1;
                state_r <= S_IDLE;
              end
            end
          end
          S_DF2: begin
            if (FIELD_END) begin
              ok_r <= 1'b1;
              state_r <= S_IDLE;
            end
          end
          default: state_r <= S_IDLE;
        endcase
      end
    end
  end

  // drive gates; header gate follows the header bit, skip and verify move nothing in the header
  always @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      WR_GATE <= 1'b0;
      RD_GATE <= 1'b0;
      FIELD_SEL <= 2'h0;
      STAT_PEND_IRQ <= 1'b0;
      ATTN_IN <= 1'b0;
    end else begin
      STAT_PEND_IRQ <= pending && irq_en_r;
      ATTN_IN <= pending && attn_en_r;
      WR_GATE <= 1'b0;
      RD_GATE <= 1'b0;
      FIELD_SEL <= 2'h0;
      if (state_r == S_HDR && op_r[`SDC_DC_HDR]) begin
        FIELD_SEL <= 2'h1;
        WR_GATE <= !op_r[`SDC_DC_READ];
        RD_GATE <= op_r[`SDC_DC_READ];
      end else if (state_r == S_DF1 || state_r == S_DF2) begin
        FIELD_SEL <= (state_r == S_DF1) ? 2'h2 : 2'h3;
        WR_GATE <= !op_r[`SDC_DC_READ];
        RD_GATE <= op_r[`SDC_DC_READ];
      end
    end
  end

endmodule // sdc_sequencer
`default_nettype wire

// ### hw/sdc_consts.vh
`ifndef SDC_CONSTS_VH
`define SDC_CONSTS_VH
// register byte offsets
`define SDC_A_CTRL 8'h00
`define SDC_A_BUSCTL 8'h04
`define SDC_A_CSTAT 8'h08
`define SDC_A_TARGET 8'h0C
`define SDC_A_HDREXP 8'h10
`define SDC_A_STATDATA 8'h14
`define SDC_A_SEQ 8'h18
`define SDC_A_EXC 8'h1C
// control register fields
`define SDC_CTRL_IRQEN 0
`define SDC_CTRL_ATTNEN 1
`define SDC_CTRL_LIRST 8
// data control code fields
`define SDC_DC_DATA 7
`define SDC_DC_READ 6
`define SDC_DC_FIXED 5
`define SDC_DC_STEP 4
`define SDC_DC_HDR 3
`define SDC_DC_MOD 2
`define SDC_DC_DF2 1
`define SDC_DC_DF1 0
`define SDC_CODE_STEP 8'h90
`define SDC_CODE_RSVD 8'hD0
`define SDC_RD_STATUS 8'h40
// controller status octet success bit
`define SDC_CS_OK 0
// status octet 0 bits
`define SDC_O0_UNSOL 6
`define SDC_O0_BCE 5
`define SDC_O0_FAULT 0
// status octet 2 bits
`define SDC_O2_INVALID 7
`define SDC_O2_UNSUP 5
`define SDC_O2_CONTEXT 4
// status response length in octets
`define SDC_STAT_OCTETS 3'h3
// ahb transfer type
`define SDC_HTRANS_NONSEQ 2'h2
`define SDC_HSIZE_WORD 3'h2
`endif

// ### bench/sdc_sequencer_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sdc_asserts #(parameter HEAD_W = 8) (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // drive side
  input wire logic FIELD_END,
  input wire logic WR_GATE,
  input wire logic RD_GATE,
  input wire logic [1:0] FIELD_SEL,
  input wire logic [HEAD_W-1:0] HEAD_ADDR,
  input wire logic XFER_END
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_wr_field_named: assert property (WR_GATE |-> FIELD_SEL != 2'h0)
    else $error("write gate without field");
  a_rd_field_named: assert property (RD_GATE |-> FIELD_SEL != 2'h0)
    else $error("read gate without field");
  a_one_direction: assert property (!(WR_GATE && RD_GATE))
    else $error("both gates high");
  a_head_single_step: assert property ($changed(HEAD_ADDR) |->
    HEAD_ADDR == $past(HEAD_ADDR) + 1'h1)
    else $error("head moved by other than one");
  a_end_is_pulse: assert property (XFER_END |=> !XFER_END)
    else $error("end held");
  // gates may only drop once the field has ended
  a_wr_gate_fall: assert property ($fell(WR_GATE) |->
    $past(FIELD_END) || $past(FIELD_END, 2))
    else $error("write gate dropped early");
  a_rd_gate_fall: assert property ($fell(RD_GATE) |->
    $past(FIELD_END) || $past(FIELD_END, 2))
    else $error("read gate dropped early");
  a_field_order: assert property ((WR_GATE || RD_GATE) && $changed(FIELD_SEL) &&
    $past(WR_GATE || RD_GATE) |-> FIELD_SEL > $past(FIELD_SEL))
    else $error("fields out of order");
  c_write: cover property ($rose(WR_GATE));
  c_read: cover property ($rose(RD_GATE));
  c_step: cover property ($changed(HEAD_ADDR));
endmodule // sdc_asserts
bind sdc_sequencer sdc_asserts #(.HEAD_W(HEAD_W)) u_sdc_asserts (.SYS_CLK(SYS_CLK), .NRST(NRST),
  .FIELD_END(FIELD_END), .WR_GATE(WR_GATE), .RD_GATE(RD_GATE), .FIELD_SEL(FIELD_SEL),
  .HEAD_ADDR(HEAD_ADDR), .XFER_END(XFER_END));
`default_nettype wire

// ### bench/sdc_disk_model.sv
`timescale 1ns/10ps
`default_nettype none
module sdc_disk_model (
  // clock
  input wire logic clk,
  // disk timing
  output logic sector_mark,
  output logic field_end,
  output logic [15:0] cur_sector,
  output logic [31:0] disk_hdr
);
  initial begin
    sector_mark = 1'h0;
    field_end = 1'h0;
    cur_sector = 16'hFFFF;
    disk_hdr = 32'h0;
  end
  // header, data field one, data field two; entered just after a rising edge
  task automatic sector(input logic [15:0] s, input logic [31:0] h);
    sector_mark <= 1'h1;
    cur_sector <= s;
    @(posedge clk);
    sector_mark <= 1'h0;
    disk_hdr <= h;
    for (int f = 0; f < 3; f++) begin
      repeat (5) @(posedge clk);
      field_end <= 1'h1;
      @(posedge clk);
      field_end <= 1'h0;
      // header no longer under the head, so a stale value must not pass
      disk_hdr <= ~h;
    end
    repeat (4) @(posedge clk);
  endtask
endmodule // sdc_disk_model
`default_nettype wire

// ### bench/sector_data_control_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sdc_consts.vh"
module sector_data_control_sequencer_tb_top;
  logic clk = 1'h0, nrst = 1'h0, hsel = 1'h0, hwrite = 1'h0, fault = 1'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, q, h;
  logic [7:0] unsol = 8'h0, eh = 8'h0;
  logic [8:0] c;
  logic [3:0] wm = 4'h0, rm = 4'h0;
  wire [31:0] hrdata, dhdr;
  wire [15:0] csec;
  wire [7:0] head;
  wire [1:0] fsel;
  wire hready, hresp, smark, fend, wrg, rdg, xend, irq, attn;
  int fail_count = 0, total_checks = 0, cyc = 0, nx = 0;
  logic [8:0] codes [25] = '{9'h084, 9'h095, 9'h086, 9'h097, 9'h197, 9'h088, 9'h089, 9'h09A,
    9'h08B, 9'h08C, 9'h09D, 9'h08E, 9'h09F, 9'h0C4, 9'h0D5, 9'h0C6, 9'h0C7, 9'h0C8, 9'h0D9,
    9'h0CA, 9'h0CB, 9'h0CC, 9'h0DD, 9'h0CE, 9'h0CF};
  logic [31:0] octs [4] = '{32'h60, 32'h4, 32'h10, 32'h0};
  sdc_sequencer u_sdc_sequencer (.SYS_CLK(clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SECTOR_MARK(smark), .FIELD_END(fend),
    .CUR_SECTOR(csec), .DISK_HDR(dhdr), .UNSOL_EVT(unsol), .DRIVE_FAULT(fault), .WR_GATE(wrg),
    .RD_GATE(rdg), .FIELD_SEL(fsel), .HEAD_ADDR(head), .XFER_END(xend), .STAT_PEND_IRQ(irq),
    .ATTN_IN(attn));
  sdc_disk_model u_sdc_disk_model (.clk(clk), .sector_mark(smark), .field_end(fend),
    .cur_sector(csec), .disk_hdr(dhdr));
  initial forever #12.5 clk = ~clk;
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (wrg) wm[fsel] = 1'h1;
    if (rdg) rm[fsel] = 1'h1;
    if (xend) nx++;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single word transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'h1;
    htrans <= `SDC_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= `SDC_HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    q = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk(q, e);
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic rs(input logic [31:0] cs);
    bus(1'h1, `SDC_A_BUSCTL, {24'h0, `SDC_RD_STATUS});
    bus(1'h1, `SDC_A_CSTAT, cs);
  endtask
  task automatic pulse_unsol(input logic [7:0] v);
    unsol <= v;
    @(posedge clk);
    unsol <= 8'h0;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    @(posedge clk);
    rdc(`SDC_A_SEQ, 32'h1);
    bus(1'h1, `SDC_A_TARGET, 32'h5);
    for (int i = 0; i < 25; i++) begin
      c = codes[i];
      h = 32'hA5C3_0000 + i;
      bus(1'h1, `SDC_A_HDREXP, c[8] ? ~h : h);
      bus(1'h1, `SDC_A_BUSCTL, {24'h0, c[7:0]});
      wm = 4'h0;
      rm = 4'h0;
      nx = 0;
      // earlier sector must be passed over by the target codes
      if (c[3:2] == 2'h3) begin
        u_sdc_disk_model.sector(16'h4, h);
        chk({wm, rm}, 32'h0);
      end
      u_sdc_disk_model.sector(16'h5, h);
      // read fields land in rm, write fields in wm, index by field select
      if (!c[6] && c[3:2] == 2'h1 && c[8]) chk({wm, rm}, 32'h0);
      else if (c[6]) chk({wm, rm}, {c[1], c[0], c[3], 1'h0});
      else chk({wm, rm}, {c[1], c[0], c[3], 5'h0});
      chk(nx, 1);
      bus(1'h0, `SDC_A_SEQ, 32'h0);
      chk(q[10:9], c[8] ? 2'h1 : 2'h2);
      if (c[4] && !c[8]) eh++;
      chk(head, eh);
    end
    bus(1'h1, `SDC_A_BUSCTL, {24'h0, `SDC_CODE_STEP});
    rdc(`SDC_A_SEQ, {8'h0, eh + 8'h1, 16'h401});
    eh++;
    bus(1'h1, `SDC_A_CTRL, 32'h3);
    bus(1'h1, `SDC_A_BUSCTL, {24'h0, `SDC_CODE_RSVD});
    rdc(`SDC_A_EXC, 32'h0080_0020);
    chk({irq, attn}, 2'h3);
    bus(1'h1, `SDC_A_BUSCTL, {24'h0, `SDC_CODE_STEP});
    eh++;
    rdc(`SDC_A_EXC, 32'h0);
    pulse_unsol(8'h04);
    bus(1'h1, `SDC_A_BUSCTL, {24'h0, `SDC_CODE_STEP});
    rdc(`SDC_A_EXC, 32'h0010_0460);
    chk(head, eh);
    bus(1'h1, `SDC_A_BUSCTL, {24'h0, `SDC_RD_STATUS});
    for (int i = 0; i < 4; i++) rdc(`SDC_A_STATDATA, octs[i]);
    bus(1'h1, `SDC_A_CSTAT, 32'h0);
    rdc(`SDC_A_EXC, 32'h0010_0460);
    rs(32'h1);
    rdc(`SDC_A_EXC, 32'h0);
    // a step while a sector operation is still waiting is out of context
    bus(1'h1, `SDC_A_BUSCTL, 32'h88);
    bus(1'h1, `SDC_A_BUSCTL, {24'h0, `SDC_CODE_STEP});
    rdc(`SDC_A_EXC, 32'h0010_0020);
    chk(head, eh);
    u_sdc_disk_model.sector(16'h7, h);
    bus(1'h1, `SDC_A_BUSCTL, 32'hA4);
    bus(1'h1, `SDC_A_BUSCTL, 32'h41);
    rdc(`SDC_A_EXC, 32'h00B0_0020);
    fault <= 1'h1;
    rs(32'h1);
    rdc(`SDC_A_EXC, 32'h1);
    fault <= 1'h0;
    rs(32'h1);
    rdc(`SDC_A_EXC, 32'h0);
    pulse_unsol(8'h80);
    bus(1'h1, `SDC_A_CTRL, 32'h100);
    rdc(`SDC_A_EXC, 32'h0);
    conclude();
  end
endmodule // sector_data_control_sequencer_tb_top
`default_nettype wire
